/* ssp_slave_port.v */
// Synchronous slave serial port with register file
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/100ps
`include "ssp_consts.vh"
module ssp_slave_port
(
  // System
  input  wire       clock_in,
  input  wire       sys_rst_in,
  // Register port
  input  wire [3:0] addr_in,
  input  wire [7:0] wdata_in,
  input  wire       wr_in,
  input  wire       rd_in,
  output reg  [7:0] rdata_out,
  // Power state
  input  wire       sleep_in,
  // Serial pins
  input  wire       shift_clock_pin_in,
  input  wire       data_pin_in,
  output reg        data_pin_out,
  output reg        data_pin_oe_out,
  // Chip events
  output reg        wake_out,
  output reg        irq_out
);
  reg  [7:0] interrupt_control_q;
  reg  [7:0] enables_q;
  reg  [7:0] prio_q;
  reg  [7:0] baud_q;
  reg  [7:0] port_g_latch_q;
  reg        port_enable_q;
  reg        rx9_q;
  reg        single_receive_enable_q;
  reg        continuous_receive_enable_q;
  reg        overrun_error_flag_q;
  reg        framing_error_flag_q;
  reg        clock_source_select_q;
  reg        tx9_q;
  reg        transmit_enable_q;
  reg        sync_q;
  reg        transmit_ninth_bit_q;
  reg  [7:0] txbuf_q;
  reg        txbuf_full_q;
  reg        txif_q;
  reg  [8:0] tsr_q;
  reg        tsr_busy_q;
  reg  [3:0] tx_cnt_q;
  reg  [8:0] rsr_q;
  reg  [3:0] rx_cnt_q;
  reg  [7:0] rxbuf_q;
  reg        rxbuf_full_q;
  reg        received_ninth_bit_buf_q;
  reg        rxif_q;
  reg        clk_prev_q;
  wire       clk_lvl;
  wire       dat_lvl;
  wire       slave_on;
  wire       rise;
  wire       fall;
  wire [3:0] tx_len;
  wire [3:0] rx_len;
  wire       tx_last;
  wire       rx_done;
  wire       buf_wr;
  wire       load_tsr;
  wire       rx_on;
  wire       rxbuf_rd;

  ssp_sync3 u_clk_sync
  (
    .clock_in   (clock_in),
    .sys_rst_in (sys_rst_in),
    .pin_in     (shift_clock_pin_in),
    .level_out  (clk_lvl)
  );

  ssp_sync3 u_dat_sync
  (
    .clock_in   (clock_in),
    .sys_rst_in (sys_rst_in),
    .pin_in     (data_pin_in),
    .level_out  (dat_lvl)
  );

  // Sleep is not consulted: the master's clock keeps us going
  assign slave_on = port_enable_q & sync_q & ~clock_source_select_q;
  assign rise     = clk_lvl & ~clk_prev_q;
  assign fall     = ~clk_lvl & clk_prev_q;
  assign tx_len   = tx9_q ? 4'h9 : 4'h8;
  assign rx_len   = rx9_q ? 4'h9 : 4'h8;
  assign buf_wr   = wr_in & (addr_in == `SSP_A_TXBUF);
  assign rxbuf_rd = rd_in & (addr_in == `SSP_A_RXBUF);
  // Single receive enable plays no part here
  assign rx_on    = slave_on & continuous_receive_enable_q & ~tsr_busy_q;
  assign tx_last  = tsr_busy_q & rise & (tx_cnt_q == tx_len - 4'h1);
  assign rx_done  = rx_on & fall & (rx_cnt_q == rx_len - 4'h1);
  // Buffer moves to the shifter as soon as it is idle
  assign load_tsr = slave_on & transmit_enable_q & txbuf_full_q &
                    (~tsr_busy_q | tx_last);

  // Register writes and status
  always @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      interrupt_control_q  <= `SSP_RST_BYTE;
      enables_q <= `SSP_RST_BYTE;
      prio_q    <= `SSP_RST_BYTE;
      baud_q    <= `SSP_RST_BYTE;
      port_g_latch_q    <= `SSP_RST_BYTE;
      port_enable_q    <= 1'b0;
      rx9_q     <= 1'b0;
      single_receive_enable_q    <= 1'b0;
      continuous_receive_enable_q    <= 1'b0;
      clock_source_select_q    <= 1'b0;
      tx9_q     <= 1'b0;
      transmit_enable_q    <= 1'b0;
      sync_q    <= 1'b0;
      transmit_ninth_bit_q    <= 1'b0;
    end
    else if (wr_in)
    begin
      case (addr_in)
        `SSP_A_INTERRUPT_CONTROL:  interrupt_control_q  <= wdata_in;
        `SSP_A_ENABLES: enables_q <= wdata_in;
        `SSP_A_PRIO:    prio_q    <= wdata_in;
        `SSP_A_BAUD:    baud_q    <= wdata_in;
        `SSP_A_PORT_G_LATCH:    port_g_latch_q    <= wdata_in;
        `SSP_A_RXSTAT:
        begin
          port_enable_q <= wdata_in[`SSP_B_PORT_ENABLE];
          rx9_q  <= wdata_in[`SSP_B_RX9];
          single_receive_enable_q <= wdata_in[`SSP_B_SINGLE_RECEIVE_ENABLE];
          continuous_receive_enable_q <= wdata_in[`SSP_B_CONTINUOUS_RECEIVE_ENABLE];
        end
        `SSP_A_TXSTAT:
        begin
          clock_source_select_q <= wdata_in[`SSP_B_CLOCK_SOURCE_SELECT];
          tx9_q  <= wdata_in[`SSP_B_TX9];
          transmit_enable_q <= wdata_in[`SSP_B_TRANSMIT_ENABLE];
          sync_q <= wdata_in[`SSP_B_SYNC];
          transmit_ninth_bit_q <= wdata_in[`SSP_B_TRANSMIT_NINTH_BIT];
        end
        default: ;
      endcase
    end
  end

  // Transmit buffer, flag and shifter
  always @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      txbuf_q         <= `SSP_RST_BYTE;
      txbuf_full_q    <= 1'b0;
      txif_q          <= 1'b0;
      tsr_q           <= 9'h000;
      tsr_busy_q      <= 1'b0;
      tx_cnt_q        <= 4'h0;
      data_pin_out    <= 1'b0;
      data_pin_oe_out <= 1'b0;
      clk_prev_q      <= 1'b0;
    end
    else
    begin
      clk_prev_q <= clk_lvl;
      if (load_tsr)
      begin
        // Ninth bit taken from the holding bit at load time
        tsr_q        <= {transmit_ninth_bit_q, txbuf_q};
        tsr_busy_q   <= 1'b1;
        tx_cnt_q     <= 4'h0;
        txbuf_full_q <= 1'b0;
        txif_q       <= 1'b1;
      end
      else if (~slave_on | ~transmit_enable_q)
      begin
        tsr_busy_q <= 1'b0;
        tx_cnt_q   <= 4'h0;
      end
      else if (tsr_busy_q & rise)
      begin
        // One bit per master clock, LSB first
        tsr_q <= {1'b0, tsr_q[8:1]};
        if (tx_last)
          tsr_busy_q <= 1'b0;
        else
          tx_cnt_q <= tx_cnt_q + 4'h1;
      end
      // Buffer write clears the flag; load in same cycle wins
      if (buf_wr & ~load_tsr)
      begin
        txbuf_q      <= wdata_in;
        txbuf_full_q <= 1'b1;
        txif_q       <= 1'b0;
      end
      else if (buf_wr)
      begin
        txbuf_q      <= wdata_in;
        txbuf_full_q <= 1'b1;
      end
      else if (~txbuf_full_q)
        txif_q <= 1'b1;
      // Drive the pin only while a word is in flight
      data_pin_oe_out <= tsr_busy_q | load_tsr;
      data_pin_out    <= load_tsr ? txbuf_q[0] :
                         (tsr_busy_q & rise) ? tsr_q[1] : tsr_q[0];
    end
  end

  // Receive shifter and buffer
  always @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      rsr_q        <= 9'h000;
      rx_cnt_q     <= 4'h0;
      rxbuf_q      <= `SSP_RST_BYTE;
      rxbuf_full_q <= 1'b0;
      received_ninth_bit_buf_q   <= 1'b0;
      rxif_q       <= 1'b0;
      overrun_error_flag_q       <= 1'b0;
      framing_error_flag_q       <= 1'b0;
    end
    else
    begin
      if (~rx_on)
        rx_cnt_q <= 4'h0;
      else if (fall)
      begin
        // Sampled on falling edge of shift clock
        if (rx9_q)
          rsr_q <= {dat_lvl, rsr_q[8:1]};
        else
          rsr_q <= {1'b0, dat_lvl, rsr_q[7:1]};
        rx_cnt_q <= rx_done ? 4'h0 : rx_cnt_q + 4'h1;
      end
      if (rx_done & rxbuf_full_q & ~rxbuf_rd)
        overrun_error_flag_q <= 1'b1;
      else if (rx_done)
      begin
        // Word lands in the buffer and raises the flag
        rxbuf_q      <= rx9_q ? rsr_q[8:1] : {dat_lvl, rsr_q[7:1]};
        received_ninth_bit_buf_q   <= rx9_q & dat_lvl;
        rxbuf_full_q <= 1'b1;
        rxif_q       <= 1'b1;
      end
      else if (rxbuf_rd)
      begin
        rxbuf_full_q <= 1'b0;
        rxif_q       <= 1'b0;
      end
      // Clearing continuous receive wipes the errors
      if (~continuous_receive_enable_q)
      begin
        overrun_error_flag_q <= 1'b0;
        framing_error_flag_q <= 1'b0;
      end
    end
  end

  // Read data, wake and interrupt
  always @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      rdata_out <= `SSP_RST_BYTE;
      wake_out  <= 1'b0;
      irq_out   <= 1'b0;
    end
    else
    begin
      // Wake needs only the local enable; vector also needs GIE and the peripheral enable
      wake_out <= (txif_q & enables_q[`SSP_B_TXIF]) |
                  (rxif_q & enables_q[`SSP_B_RXIF]);
      irq_out  <= interrupt_control_q[`SSP_B_GIE] & interrupt_control_q[`SSP_B_PERIPHERAL_INTERRUPT_ENABLE] &
                  ((txif_q & enables_q[`SSP_B_TXIF]) |
                   (rxif_q & enables_q[`SSP_B_RXIF]));
      rdata_out <= 8'h00;
      if (rd_in)
      begin
        case (addr_in)
          `SSP_A_INTERRUPT_CONTROL:  rdata_out <= interrupt_control_q;
          `SSP_A_FLAGS:   rdata_out <= {2'b00, rxif_q, txif_q, 4'h0};
          `SSP_A_ENABLES: rdata_out <= enables_q;
          `SSP_A_PRIO:    rdata_out <= prio_q;
          `SSP_A_RXSTAT:  rdata_out <= {port_enable_q, rx9_q, single_receive_enable_q, continuous_receive_enable_q,
                                        1'b0, framing_error_flag_q, overrun_error_flag_q, received_ninth_bit_buf_q};
          `SSP_A_TXBUF:   rdata_out <= txbuf_q;
          `SSP_A_TXSTAT:  rdata_out <= {clock_source_select_q, tx9_q, transmit_enable_q, sync_q,
                                        2'b00, ~tsr_busy_q, transmit_ninth_bit_q};
          `SSP_A_BAUD:    rdata_out <= baud_q;
          `SSP_A_PORT_G_LATCH:    rdata_out <= port_g_latch_q;
          `SSP_A_RXBUF:   rdata_out <= rxbuf_q;
          default:        rdata_out <= 8'h00;
        endcase
      end
    end
  end
endmodule

/* ssp_consts.vh */
// Constants for the synchronous serial slave port
// Behaviour
// - Clearing clock source bit 7 selects slave
// - Master drives shift clock; device never does
// - Transfers continue in any low-power mode
// - Slave transmit behaves like master transmit; with bit 7 set the port never shifts or drives the pin
// - Two words then sleep: first sends, second waits
// - Second word loads, then transmit flag sets
// - Transmit flag with enable wakes chip
// - Transmit enable, then buffer write starts shift
// - Single receive enable ignored in slave
// - Continuous receive works in low-power mode
// - Received word moves to buffer; may wake
// - Receive flag sets on completed word
// - Ninth bit and errors in status register
// - Clearing continuous receive clears errors
// - Transmit flag clears only on buffer write
// - Receive samples data on falling clock edge
`ifndef SSP_CONSTS_VH
`define SSP_CONSTS_VH
`define SSP_A_INTERRUPT_CONTROL   4'h0
`define SSP_A_FLAGS    4'h1
`define SSP_A_ENABLES  4'h2
`define SSP_A_PRIO     4'h3
`define SSP_A_RXSTAT   4'h4
`define SSP_A_TXBUF    4'h5
`define SSP_A_TXSTAT   4'h6
`define SSP_A_BAUD     4'h7
`define SSP_A_PORT_G_LATCH     4'h8
`define SSP_A_RXBUF    4'h9
`define SSP_B_GIE      7
`define SSP_B_PERIPHERAL_INTERRUPT_ENABLE     6
`define SSP_B_RXIF     5
`define SSP_B_TXIF     4
`define SSP_B_PORT_ENABLE     7
`define SSP_B_RX9      6
`define SSP_B_SINGLE_RECEIVE_ENABLE     5
`define SSP_B_CONTINUOUS_RECEIVE_ENABLE     4
`define SSP_B_FRAMING_ERROR_FLAG     2
`define SSP_B_OVERRUN_ERROR_FLAG     1
`define SSP_B_RECEIVED_NINTH_BIT     0
`define SSP_B_CLOCK_SOURCE_SELECT     7
`define SSP_B_TX9      6
`define SSP_B_TRANSMIT_ENABLE     5
`define SSP_B_SYNC     4
`define SSP_B_TRMT     1
`define SSP_B_TRANSMIT_NINTH_BIT     0
`define SSP_RST_BYTE   8'h00
`define SSP_RST_TXSTAT 8'h02
`endif

/* ssp_sync3.v */
// Three-stage pin synchroniser with agreement check
`timescale 1ns/100ps
module ssp_sync3
(
  // Clock and reset
  input  wire clock_in,
  input  wire sys_rst_in,
  // Pin and filtered level
  input  wire pin_in,
  output reg  level_out
);
  reg s1_q;
  reg s2_q;
  reg s3_q;

  always @(posedge clock_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      s1_q      <= 1'b0;
      s2_q      <= 1'b0;
      s3_q      <= 1'b0;
      level_out <= 1'b0;
    end
    else
    begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // Change counts only once stages two and three agree
      if (s2_q == s3_q)
        level_out <= s3_q;
    end
  end
endmodule

/* ssp_slave_port_asserts.sv */
// Port checks for the slave serial port
`timescale 1ns/100ps
module ssp_slave_port_asserts
(
  // Watched ports
  input wire       clock_in,
  input wire       sys_rst_in,
  input wire [3:0] addr_in,
  input wire [7:0] wdata_in,
  input wire       wr_in,
  input wire       rd_in,
  input wire [7:0] rdata_out,
  input wire       shift_clock_pin_in,
  input wire       data_pin_out,
  input wire       data_pin_oe_out,
  input wire       wake_out,
  input wire       irq_out
);
  reg  [1:0] gp_q;
  reg        sc_q;
  reg  [3:0] age_q;
  wire       tx_wr = wr_in && addr_in == 4'h5;
  // Pin release and data changes may only come shortly after a raw clock rise
  always @(posedge clock_in or posedge sys_rst_in)
    if (sys_rst_in)
    begin
      gp_q  <= 2'h0;
      sc_q  <= 1'b0;
      age_q <= 4'hF;
    end
    else
    begin
      sc_q <= shift_clock_pin_in;
      if (wr_in && addr_in == 4'h0)
        gp_q <= wdata_in[7:6];
      if (shift_clock_pin_in && !sc_q)
        age_q <= 4'h0;
      else if (age_q != 4'hF)
        age_q <= age_q + 4'h1;
    end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  a_rd_quiet: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data outside slot");
  a_rd_unmapped: assert property ($past(rd_in && addr_in > 4'h9)
    |-> rdata_out == 8'h00) else $error("unmapped read");
  a_interrupt_control_read: assert property ($past(rd_in && addr_in == 4'h0)
    |-> rdata_out[7:6] == $past(gp_q)) else $error("enable bits");
  a_irq_gate: assert property (
    irq_out == (wake_out && $past(gp_q) == 2'h3)) else $error("irq gate");
  a_irq_wake: assert property (irq_out |-> wake_out)
    else $error("irq without wake");
  a_oe_start: assert property ($rose(data_pin_oe_out) |->
    $past(tx_wr) || $past(tx_wr, 2) || $past(tx_wr, 3))
    else $error("drive without write");
  a_oe_stop: assert property ($fell(data_pin_oe_out) |-> age_q < 4'hB)
    else $error("release off clock");
  a_pin_steady: assert property (data_pin_oe_out &&
    $past(data_pin_oe_out) && $changed(data_pin_out) |-> age_q < 4'hB)
    else $error("data moved off clock");
endmodule
bind ssp_slave_port ssp_slave_port_asserts u_chk
(
  .clock_in, .sys_rst_in, .addr_in, .wdata_in, .wr_in, .rd_in,
  .rdata_out, .shift_clock_pin_in, .data_pin_out, .data_pin_oe_out,
  .wake_out, .irq_out
);

/* ssp_master_model.sv */
// Outside master that clocks the slave port's pins
`timescale 1ns/100ps
module ssp_master_model
(
  // Line as seen by the master
  input  wire pin_in,
  // Master drives
  output reg  sclk_out,
  output reg  dat_out,
  output reg  en_out
);
  initial
  begin
    sclk_out = 1'b0;
    dat_out  = 1'b0;
    en_out   = 1'b0;
  end
  // Clock runs only inside a frame
  task xfer(input [8:0] tx, input int n, input bit drv,
            output logic [8:0] rx);
    int i;
    rx     = 9'h000;
    en_out = drv;
    for (i = 0; i < n; i++)
    begin
      #40 dat_out = tx[i];
      #40 rx[i] = pin_in;
      sclk_out = 1'b1;
      #80 sclk_out = 1'b0; // Data held past this edge
    end
    // Slow release lets the port see the last edge
    #200 en_out = 1'b0;
  endtask
endmodule

/* ssp_slave_port_tb.sv */
// Self-checking bench for the slave serial port
`timescale 1ns/100ps
module ssp_slave_port_tb;
  reg        clock_in;
  reg        sys_rst_in;
  reg  [3:0] addr_in;
  reg  [7:0] wdata_in;
  reg        wr_in;
  reg        rd_in;
  reg        sleep_in;
  wire [7:0] rdata_out;
  wire       shift_clock_pin_in;
  wire       m_dat;
  wire       m_en;
  wire       data_pin_out;
  wire       data_pin_oe_out;
  wire       wake_out;
  wire       irq_out;
  reg  [8:0] got;
  int        failures;
  int        total_checks;
  // Released line shows the inverse of the master's data
  wire       data_pin_in = data_pin_oe_out ? data_pin_out :
                           (m_en ? m_dat : ~m_dat);
  ssp_slave_port DUT
  (
    .clock_in, .sys_rst_in, .addr_in, .wdata_in, .wr_in, .rd_in,
    .rdata_out, .sleep_in, .shift_clock_pin_in, .data_pin_in,
    .data_pin_out, .data_pin_oe_out, .wake_out, .irq_out
  );
  ssp_master_model M
  (
    .pin_in(data_pin_in), .sclk_out(shift_clock_pin_in),
    .dat_out(m_dat), .en_out(m_en)
  );
  initial
  begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end
  task tally_and_finish;
    if (failures == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input string n, input [8:0] e, input [8:0] g);
    total_checks++;
    if (e !== g)
    begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input [3:0] a, input [7:0] d);
    @(posedge clock_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge clock_in);
    wr_in    <= 1'b0;
  endtask
  task rd(input [3:0] a, input [7:0] e);
    @(posedge clock_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clock_in);
    rd_in   <= 1'b0;
    @(negedge clock_in);
    chk($sformatf("reg %h", a), e, rdata_out);
  endtask
  task s_reset;
    rd(4'h6, 8'h02);
    wr(4'h1, 8'h00);
    rd(4'h1, 8'h10);
    rd(4'hC, 8'h00);
  endtask
  task s_tx;
    wr(4'h4, 8'h80);
    wr(4'h6, 8'h71);
    wr(4'h2, 8'h10);
    wr(4'h0, 8'hC0);
    wr(4'h5, 8'hA5);
    wr(4'h5, 8'h3C);
    sleep_in <= 1'b1;
    rd(4'h1, 8'h00);
    chk("wake", 1'b0, wake_out);
    M.xfer(9'h000, 9, 1'b0, got);
    chk("word", 9'h1A5, got);
    chk("wake", 1'b1, wake_out);
    chk("irq", 1'b1, irq_out);
    M.xfer(9'h000, 9, 1'b0, got);
    chk("word", 9'h13C, got);
    rd(4'h6, 8'h73);
    chk("drive", 1'b0, data_pin_oe_out);
  endtask
  task s_rx;
    wr(4'h6, 8'h10);
    wr(4'h2, 8'h20);
    wr(4'h4, 8'hA0);
    M.xfer(9'h0C3, 8, 1'b1, got);
    rd(4'h1, 8'h10);
    wr(4'h4, 8'hD0);
    M.xfer(9'h13C, 9, 1'b1, got);
    chk("wake", 1'b1, wake_out);
    chk("irq", 1'b1, irq_out);
    rd(4'h1, 8'h30);
    rd(4'h4, 8'hD1);
    rd(4'h9, 8'h3C);
    rd(4'h1, 8'h10);
  endtask
  task s_ovr;
    M.xfer(9'h055, 9, 1'b1, got);
    M.xfer(9'h0AA, 9, 1'b1, got);
    rd(4'h4, 8'hD2);
    wr(4'h4, 8'hC0);
    rd(4'h4, 8'hC0);
    rd(4'h9, 8'h55);
  endtask
  task s_master;
    sleep_in <= 1'b0;
    wr(4'h6, 8'hB0);
    wr(4'h5, 8'h81);
    rd(4'h6, 8'hB2);
    chk("drive", 1'b0, data_pin_oe_out);
  endtask
  initial
  begin
    sys_rst_in   = 1'b1;
    addr_in      = 4'h0;
    wdata_in     = 8'h00;
    wr_in        = 1'b0;
    rd_in        = 1'b0;
    sleep_in     = 1'b0;
    failures     = 0;
    total_checks = 0;
    repeat (12) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    // Transmit flag rises one cycle after reset
    repeat (3) @(posedge clock_in);
    s_reset;
    s_tx;
    s_rx;
    s_ovr;
    s_master;
    tally_and_finish;
  end
endmodule
